// ---- pmi_regs.svh ----
// Timing constants for the MAC-facing data interface
`ifndef PMI_REGS_SVH
`define PMI_REGS_SVH

// ----------------------------------------------------------------------
// Clock rates in kHz
// ----------------------------------------------------------------------
`define PMI_SYS_CLK_KHZ 10000
`define PMI_TX10_KHZ 2500
`define PMI_TX100_KHZ 25000
`define PMI_RX10_KHZ 2500
`define PMI_RX100_KHZ 25000
`define PMI_RX1000_KHZ 125000

// ----------------------------------------------------------------------
// Half periods in system cycles, rounded down, never below one
// ----------------------------------------------------------------------
`define PMI_HALF(r) (((`PMI_SYS_CLK_KHZ / (2 * (r))) > 0) ? (`PMI_SYS_CLK_KHZ / (2 * (r))) : 1)
`define PMI_TX10_HALF `PMI_HALF(`PMI_TX10_KHZ)
`define PMI_TX100_HALF `PMI_HALF(`PMI_TX100_KHZ)
`define PMI_RX10_HALF `PMI_HALF(`PMI_RX10_KHZ)
`define PMI_RX100_HALF `PMI_HALF(`PMI_RX100_KHZ)
`define PMI_RX1000_HALF `PMI_HALF(`PMI_RX1000_KHZ)

`endif

// ---- pmi_pkg.sv ----
// Types shared by the MAC-facing data interface
package pmi_pkg;

  // --------------------------------------------------------------------
  // Modes, symbol kinds and error-run states
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMI_MII = 2'h0,
    PMI_GMII = 2'h1,
    PMI_RGMII = 2'h2
  } pmi_if_e;

  typedef enum logic [1:0] {
    PMI_10M = 2'h0,
    PMI_100M = 2'h1,
    PMI_1000M = 2'h2
  } pmi_speed_e;

  typedef enum logic [1:0] {
    PMI_SYM_DATA = 2'h0,
    PMI_SYM_INVALID = 2'h1,
    PMI_SYM_HALT = 2'h2
  } pmi_sym_e;

  typedef enum logic [2:0] {
    PMI_TE_OK = 3'h1,
    PMI_TE_INV = 3'h2,
    PMI_TE_HALT = 3'h4
  } pmi_terr_e;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    pmi_sym_e kind;
    logic [7:0] data;
  } pmi_sym_s;

  typedef struct packed {
    logic [7:0] data;
    logic err;
  } pmi_rxb_s;

endpackage : pmi_pkg

// ---- pmi_fifo.sv ----
// Small valid/ready buffer for transmit symbols
`timescale 1ns/1ps
`default_nettype none

module pmi_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Fill side
  input wire logic i_valid,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_ready,
  // Drain side
  output logic o_valid,
  output logic [WIDTH-1:0] o_data,
  input wire logic i_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW-1:0] rd_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nxt

  assign push = i_valid & o_ready;
  assign pop = o_valid & i_ready;
  assign cnt_d = cnt_q + CW'(push) - CW'(pop);
  assign rd_d = pop ? nxt(rd_q) : rd_q;

  // ----------------------------------------------------------------------
  // Pointers and flags
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      o_valid <= 1'b0;
      o_ready <= 1'b1;
      o_data <= '0;
    end
    else
    begin
      if (push)
        wr_q <= nxt(wr_q);
      if (pop)
        rd_q <= nxt(rd_q);
      cnt_q <= cnt_d;
      o_valid <= (cnt_d != '0);
      o_ready <= (cnt_d != CW'(DEPTH));
      // Head word is registered so the output comes straight from a flop
      o_data <= (push && wr_q == rd_d) ? i_data : mem_q[rd_d];
    end
  end

  // Storage needs no reset; valid guards it
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wr_q] <= i_data;
  end

endmodule : pmi_fifo
`default_nettype wire

// ---- pmi_core.sv ----
// MAC-facing transmit and receive data path of the transceiver
`include "pmi_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pmi_core #(
  parameter int TXQ_DEPTH = 2
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Mode straps
  input wire pmi_pkg::pmi_if_e i_if_mode,
  input wire pmi_pkg::pmi_speed_e i_speed,
  // MAC transmit pins
  input wire logic i_gtx_clk,
  input wire logic [7:0] i_txd,
  input wire logic i_tx_en,
  input wire logic i_tx_er,
  output logic o_tx_clk,
  // Line-side transmit symbols
  output logic o_sym_valid,
  output pmi_pkg::pmi_sym_s o_sym,
  input wire logic i_sym_ready,
  output logic o_tx_overrun,
  // Line-side receive bytes
  input wire logic i_rx_valid,
  input wire pmi_pkg::pmi_rxb_s i_rx_byte,
  output logic o_rx_ready,
  // MAC receive pins
  output logic o_rx_clk,
  output logic [3:0] o_rxd,
  output logic o_rx_ctl,
  output logic o_rx_er
);
  import pmi_pkg::*;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  logic gtx_s1, gtx_s2, gtx_s3;
  logic [7:0] txd_s1, txd_s2;
  logic en_s1, en_s2, er_s1, er_s2;
  logic gtx_rise, gtx_fall;

  // Pins come from MAC clock; two flops before use
  always_ff @(posedge i_sys_clk)
  begin
    gtx_s1 <= i_gtx_clk;
    gtx_s2 <= gtx_s1;
    gtx_s3 <= gtx_s2;
    txd_s1 <= i_txd;
    txd_s2 <= txd_s1;
    en_s1 <= i_tx_en;
    en_s2 <= en_s1;
    er_s1 <= i_tx_er;
    er_s2 <= er_s1;
  end

  // Relies on the MAC clock running during frames
  assign gtx_rise = gtx_s2 & ~gtx_s3;
  assign gtx_fall = ~gtx_s2 & gtx_s3;

  function automatic logic [7:0] tx_half(input pmi_speed_e s);
    return (s == PMI_10M) ? 8'(`PMI_TX10_HALF) : 8'(`PMI_TX100_HALF);
  endfunction : tx_half

  function automatic logic [7:0] rx_half(input pmi_speed_e s);
    unique case (s)
      PMI_10M: return 8'(`PMI_RX10_HALF);
      PMI_100M: return 8'(`PMI_RX100_HALF);
      default: return 8'(`PMI_RX1000_HALF);
    endcase
  endfunction : rx_half

  // ----------------------------------------------------------------------
  // MII transmit clock
  // ----------------------------------------------------------------------
  logic [7:0] txc_cnt_q;
  logic txc_tick, mii_tx_rise, is_mii;

  assign is_mii = (i_if_mode == PMI_MII);
  assign txc_tick = is_mii && (txc_cnt_q >= tx_half(i_speed) - 8'h01);
  assign mii_tx_rise = txc_tick & ~o_tx_clk;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || !is_mii)
    begin
      txc_cnt_q <= 8'h00;
      o_tx_clk <= 1'b0;
    end
    else if (txc_tick)
    begin
      txc_cnt_q <= 8'h00;
      o_tx_clk <= ~o_tx_clk;
    end
    else
      txc_cnt_q <= txc_cnt_q + 8'h01;
  end

  // ----------------------------------------------------------------------
  // Transmit capture
  // ----------------------------------------------------------------------
  logic [3:0] lo_q;
  logic half_q, nib_er_q, ctl_r_q;
  logic raw_v, raw_er, cap_v_q, cap_fire, txq_ready;
  logic [7:0] raw_b;
  pmi_sym_e raw_kind;
  pmi_sym_s cap_q;
  pmi_terr_e terr_q;

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      lo_q <= 4'h0;
      half_q <= 1'b0;
      nib_er_q <= 1'b0;
      ctl_r_q <= 1'b0;
    end
    else if (i_if_mode == PMI_RGMII && gtx_rise)
    begin
      lo_q <= txd_s2[3:0];
      ctl_r_q <= en_s2;
    end
    else if (mii_tx_rise)
    begin
      if (!en_s2)
        half_q <= 1'b0;
      else if (!half_q)
      begin
        lo_q <= txd_s2[3:0];
        nib_er_q <= er_s2;
        half_q <= 1'b1;
      end
      else
        half_q <= 1'b0;
    end
  end

  always_comb
  begin
    raw_v = 1'b0;
    raw_b = 8'h00;
    raw_er = 1'b0;
    unique case (i_if_mode)
      PMI_GMII:
        if (gtx_rise && en_s2)
        begin
          raw_v = 1'b1;
          raw_b = txd_s2;
          raw_er = er_s2;
        end
      PMI_RGMII:
        if (gtx_fall && ctl_r_q)
        begin
          raw_v = 1'b1;
          raw_b = {txd_s2[3:0], lo_q};
          raw_er = ctl_r_q ^ en_s2;
        end
      PMI_MII:
        if (mii_tx_rise && en_s2 && half_q)
        begin
          raw_v = 1'b1;
          raw_b = {txd_s2[3:0], lo_q};
          raw_er = nib_er_q | er_s2;
        end
      default: ;
    endcase
    if (!raw_er)
      raw_kind = PMI_SYM_DATA;
    else if (!is_mii || terr_q == PMI_TE_OK)
      raw_kind = PMI_SYM_INVALID;
    else
      raw_kind = PMI_SYM_HALT;
  end

  // A word that finds the holding stage blocked is dropped and flagged
  assign cap_fire = raw_v & ~(cap_v_q & ~txq_ready);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      terr_q <= PMI_TE_OK;
    else if (mii_tx_rise && !er_s2)
      terr_q <= PMI_TE_OK;
    else if (is_mii && cap_fire && raw_er)
      terr_q <= (terr_q == PMI_TE_OK) ? PMI_TE_INV : PMI_TE_HALT;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cap_v_q <= 1'b0;
      cap_q <= '0;
      o_tx_overrun <= 1'b0;
    end
    else
    begin
      o_tx_overrun <= raw_v & ~cap_fire;
      if (cap_fire)
      begin
        cap_v_q <= 1'b1;
        cap_q <= '{kind: raw_kind, data: raw_b};
      end
      else if (txq_ready)
        cap_v_q <= 1'b0;
    end
  end

  pmi_fifo #(
    .WIDTH($bits(pmi_sym_s)),
    .DEPTH(TXQ_DEPTH)
  ) u_txq (
    .i_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_valid(cap_v_q),
    .i_data(cap_q),
    .o_ready(txq_ready),
    .o_valid(o_sym_valid),
    .o_data(o_sym),
    .i_ready(i_sym_ready)
  );

  // ----------------------------------------------------------------------
  // Receive clock and data
  // ----------------------------------------------------------------------
  logic [7:0] rxc_cnt_q;
  logic rx_tick, rx_rise, rx_fall, rx_clk_d;
  logic rx_have_q, rx_have_d, rx_take, rx_consume, rx_nib_q, rg_dv_q, is_rg;
  pmi_rxb_s rx_cur_q;

  assign is_rg = (i_if_mode == PMI_RGMII);
  assign rx_tick = (rxc_cnt_q >= rx_half(i_speed) - 8'h01);
  assign rx_rise = rx_tick & ~o_rx_clk;
  assign rx_fall = rx_tick & o_rx_clk;
  assign rx_clk_d = rx_tick ? ~o_rx_clk : o_rx_clk;
  assign rx_take = o_rx_ready & i_rx_valid;
  assign rx_consume = rx_have_q && rx_fall && (is_rg ? rg_dv_q : (!is_mii || rx_nib_q));
  assign rx_have_d = rx_take | (rx_have_q & ~rx_consume);

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rxc_cnt_q <= 8'h00;
      o_rx_clk <= 1'b0;
    end
    else
    begin
      rxc_cnt_q <= rx_tick ? 8'h00 : rxc_cnt_q + 8'h01;
      o_rx_clk <= rx_clk_d;
    end
  end

  // In RGMII a byte may only load while the clock is low, so both halves match
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      rx_have_q <= 1'b0;
      rx_cur_q <= '0;
      o_rx_ready <= 1'b0;
    end
    else
    begin
      rx_have_q <= rx_have_d;
      if (rx_take)
        rx_cur_q <= i_rx_byte;
      o_rx_ready <= ~rx_have_d & (~is_rg | ~rx_clk_d);
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_rxd <= 4'h0;
      o_rx_ctl <= 1'b0;
      o_rx_er <= 1'b0;
      rx_nib_q <= 1'b0;
      rg_dv_q <= 1'b0;
    end
    else if (is_rg)
    begin
      o_rx_er <= 1'b0;
      rx_nib_q <= 1'b0;
      if (rx_rise)
      begin
        o_rxd <= rx_have_q ? rx_cur_q.data[3:0] : 4'h0;
        o_rx_ctl <= rx_have_q;
        rg_dv_q <= rx_have_q;
      end
      else if (rx_fall)
      begin
        o_rxd <= rg_dv_q ? rx_cur_q.data[7:4] : 4'h0;
        o_rx_ctl <= rg_dv_q & ~rx_cur_q.err;
      end
    end
    else if (rx_fall)
    begin
      rg_dv_q <= 1'b0;
      o_rx_ctl <= rx_have_q;
      o_rx_er <= rx_have_q & rx_cur_q.err;
      o_rxd <= !rx_have_q ? 4'h0 : (is_mii && rx_nib_q) ? rx_cur_q.data[7:4] :
               rx_cur_q.data[3:0];
      if (is_mii && rx_have_q)
        rx_nib_q <= ~rx_nib_q;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  localparam int TXC_MAX = `PMI_TX10_HALF;
  localparam int RXC_MAX = `PMI_RX10_HALF;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_rg_rise;
    is_rg && rx_rise && rx_have_q;
  endsequence
  sequence s_rg_low;
    o_rx_ctl && o_rxd == $past(rx_cur_q.data[3:0]);
  endsequence
  sequence s_gmii_err;
    i_if_mode == PMI_GMII && cap_fire && raw_er;
  endsequence

  tx_clk_run_a: assert property (is_mii && $stable(i_speed) |-> ##[1:TXC_MAX] $changed(o_tx_clk))
    else $error("transmit clock stalled in MII mode");
  tx_clk_rate_a: assert property (is_mii && i_speed == PMI_10M && $past(i_speed) == PMI_10M && $changed(o_tx_clk) |=> $stable(o_tx_clk) ##1 $changed(o_tx_clk))
    else $error("10 Mbps transmit clock half period wrong");
  gmii_byte_a: assert property (i_if_mode == PMI_GMII && gtx_rise && en_s2 && cap_fire |=> cap_v_q && cap_q.data == $past(txd_s2))
    else $error("GMII byte not captured on gigabit clock");
  mii_nibble_a: assert property (mii_tx_rise && en_s2 && !half_q |=> half_q && lo_q == $past(txd_s2[3:0]))
    else $error("MII low nibble not captured");
  gmii_err_a: assert property (s_gmii_err |=> cap_q.kind == PMI_SYM_INVALID)
    else $error("GMII error byte not invalid");
  mii_halt_a: assert property (is_mii && cap_fire && raw_er && terr_q != PMI_TE_OK |=> cap_q.kind == PMI_SYM_HALT)
    else $error("MII error run not sending Halt");
  rx_clk_run_a: assert property ($stable(i_speed) |-> ##[1:RXC_MAX] $changed(o_rx_clk))
    else $error("receive clock stalled");
  rx_valid_a: assert property (!is_rg && rx_fall && rx_have_q |=> o_rx_ctl)
    else $error("receive valid missing");
  rg_rx_low_a: assert property (s_rg_rise |=> s_rg_low)
    else $error("RGMII rising half wrong");
  rg_tx_byte_a: assert property (is_rg && gtx_fall && ctl_r_q && cap_fire |=> cap_q.data[3:0] == $past(lo_q))
    else $error("RGMII transmit byte pairing wrong");

endmodule : pmi_core
`default_nettype wire

// ---- pmi_mac_model.sv ----
// Behavioural MAC driving the transmit pins of the data interface
`timescale 1ns/1ps
`default_nettype none
module pmi_mac_model (
  // Mode and device transmit clock
  input wire pmi_pkg::pmi_if_e i_if_mode,
  input wire logic i_tx_clk,
  // Transmit pins
  output logic o_gtx_clk,
  output logic [7:0] o_txd,
  output logic o_tx_en,
  output logic o_tx_er
);
  import pmi_pkg::*;
  initial
  begin
    o_gtx_clk = 1'b0;
    o_txd = 8'h00;
    o_tx_en = 1'b0;
    o_tx_er = 1'b0;
  end
  // Runs free between frames too; slowed so the 10 MHz core can sample it
  always #400 o_gtx_clk = ~o_gtx_clk;
  // Launch on the edge opposite the sampling edge, in RGMII a quarter period after it; unused bits carry junk
  task automatic send(input logic [7:0] b, input logic er);
    if (i_if_mode == PMI_MII)
    begin
      @(negedge i_tx_clk);
      o_txd <= {~b[3:0], b[3:0]};
      o_tx_en <= 1'b1;
      o_tx_er <= er;
      @(negedge i_tx_clk);
      o_txd <= {~b[7:4], b[7:4]};
    end
    else if (i_if_mode == PMI_RGMII)
    begin
      // Quarter-period offset keeps each nibble clear of both sampled edges
      @(negedge o_gtx_clk);
      #200;
      o_txd <= {~b[3:0], b[3:0]};
      o_tx_en <= 1'b1;
      @(posedge o_gtx_clk);
      #200;
      o_txd <= {~b[7:4], b[7:4]};
      o_tx_en <= ~er;
    end
    else
    begin
      @(negedge o_gtx_clk);
      o_txd <= b;
      o_tx_en <= 1'b1;
      o_tx_er <= er;
    end
  endtask : send
  // Pins fall back to their pull-down level
  task automatic idle();
    if (i_if_mode == PMI_MII)
      @(negedge i_tx_clk);
    else
    begin
      @(negedge o_gtx_clk);
      #200;
    end
    o_txd <= 8'h00;
    o_tx_en <= 1'b0;
    o_tx_er <= 1'b0;
  endtask : idle
endmodule : pmi_mac_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the MAC-facing data interface
`include "pmi_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sym_rdy = 1'b1;
  logic rx_v = 1'b0;
  pmi_if_e mode = PMI_GMII;
  pmi_speed_e spd = PMI_1000M;
  pmi_rxb_s rx_b = '0;
  logic gtx, tx_en, tx_er, tx_clk, sym_v, ovr, rx_rdy, rx_clk, rx_ctl, rx_er;
  logic [7:0] txd;
  logic [3:0] rxd;
  pmi_sym_s sym;
  pmi_sym_s got[$];
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_ovr = 0;
  pmi_core pmi_core_i (.i_sys_clk(clk), .i_reset(rst), .i_if_mode(mode), .i_speed(spd),
    .i_gtx_clk(gtx), .i_txd(txd), .i_tx_en(tx_en), .i_tx_er(tx_er), .o_tx_clk(tx_clk),
    .o_sym_valid(sym_v), .o_sym(sym), .i_sym_ready(sym_rdy), .o_tx_overrun(ovr),
    .i_rx_valid(rx_v), .i_rx_byte(rx_b), .o_rx_ready(rx_rdy), .o_rx_clk(rx_clk),
    .o_rxd(rxd), .o_rx_ctl(rx_ctl), .o_rx_er(rx_er));
  pmi_mac_model pmi_mac_model_i (.i_if_mode(mode), .i_tx_clk(tx_clk), .o_gtx_clk(gtx),
    .o_txd(txd), .o_tx_en(tx_en), .o_tx_er(tx_er));
  always #50 clk = ~clk;
  // Bounds every wait on a link clock edge
  initial
  begin
    repeat (90000) @(posedge clk);
    timeout("run length");
  end
  // Symbols are logged at the edge that accepts them
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (sym_v === 1'b1 && sym_rdy === 1'b1) got.push_back(sym);
    if (ovr === 1'b1) n_ovr <= n_ovr + 1;
  end
  // ----
  // Helpers
  // ----
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(string w, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick
  task automatic timeout(string w);
    chk(w, 16'h1, 16'h0);
    end_sim();
  endtask : timeout
  task automatic tx(logic [7:0] b, logic e);
    pmi_mac_model_i.send(b, e);
  endtask : tx
  task automatic setmode(pmi_if_e m, pmi_speed_e s);
    rst = 1'b1;
    mode = m;
    spd = s;
    repeat (8) tick();
    chk("reset outputs", 16'h0, {tx_clk, sym_v, ovr, rx_rdy, rx_clk, rxd, rx_ctl, rx_er});
    rst = 1'b0;
    repeat (3) tick();
    got.delete();
    n_ovr = 0;
  endtask : setmode
  task automatic wait_syms(int n);
    int k;
    for (k = 0; k < 300 && got.size() < n; k++) tick();
    if (got.size() < n) timeout("symbol count");
  endtask : wait_syms
  // Cycles between two rising edges of the chosen clock, 0 if it stands
  task automatic period(logic rx, output int n);
    int r[$];
    logic p, s;
    p = 1'b1;
    repeat (100)
    begin
      tick();
      s = rx ? rx_clk : tx_clk;
      if (s === 1'b1 && p === 1'b0) r.push_back(cyc);
      p = s;
    end
    n = (r.size() >= 3) ? r[2] - r[1] : 0;
  endtask : period
  task automatic rx_put(logic [7:0] d, logic e);
    int k;
    rx_b = '{data: d, err: e};
    rx_v = 1'b1;
    for (k = 0; k < 50 && rx_rdy !== 1'b1; k++) tick();
    tick();
    rx_v = 1'b0;
    rx_b = ~rx_b;
    if (k == 50) timeout("rx ready");
  endtask : rx_put
  task automatic rx_edge(logic r);
    logic p;
    int k;
    p = rx_clk;
    for (k = 0; k < 50; k++)
    begin
      tick();
      if (rx_clk === r && p === ~r) break;
      p = rx_clk;
    end
    if (k == 50) timeout("rx clock edge");
  endtask : rx_edge
  // ----
  // Scenarios
  // ----
  task automatic t_gmii();
    int n;
    setmode(PMI_GMII, PMI_1000M);
    tx(8'hA5, 1'b0);
    tx(8'h3C, 1'b1);
    tx(8'hF0, 1'b0);
    pmi_mac_model_i.idle();
    wait_syms(3);
    chk("gmii byte", {PMI_SYM_DATA, 8'hA5}, got[0]);
    chk("gmii error", PMI_SYM_INVALID, got[1].kind);
    chk("gmii high bits", {PMI_SYM_DATA, 8'hF0}, got[2]);
    period(1'b0, n);
    chk("tx clock off", 16'h0, n);
  endtask : t_gmii
  task automatic t_rgmii();
    setmode(PMI_RGMII, PMI_1000M);
    tx(8'h5A, 1'b0);
    tx(8'h77, 1'b1);
    tx(8'hE1, 1'b0);
    pmi_mac_model_i.idle();
    wait_syms(3);
    chk("rgmii byte", {PMI_SYM_DATA, 8'h5A}, got[0]);
    chk("rgmii error", PMI_SYM_INVALID, got[1].kind);
    chk("rgmii next", {PMI_SYM_DATA, 8'hE1}, got[2]);
  endtask : t_rgmii
  task automatic t_mii();
    int n;
    setmode(PMI_MII, PMI_100M);
    period(1'b0, n);
    chk("tx clock 100M", 2 * `PMI_TX100_HALF, n);
    setmode(PMI_MII, PMI_10M);
    period(1'b0, n);
    chk("tx clock 10M", 2 * `PMI_TX10_HALF, n);
    tx(8'hC3, 1'b0);
    tx(8'h11, 1'b1);
    tx(8'h22, 1'b1);
    tx(8'h96, 1'b0);
    pmi_mac_model_i.idle();
    wait_syms(4);
    chk("mii nibbles", {PMI_SYM_DATA, 8'hC3}, got[0]);
    chk("mii first error", PMI_SYM_INVALID, got[1].kind);
    chk("mii held error", PMI_SYM_HALT, got[2].kind);
    chk("mii after error", {PMI_SYM_DATA, 8'h96}, got[3]);
  endtask : t_mii
  // Stalled line side: two in the buffer, one held, the fourth dropped
  task automatic t_buf();
    int k;
    setmode(PMI_GMII, PMI_1000M);
    sym_rdy = 1'b0;
    for (int i = 0; i < 4; i++) tx(8'h40 + 8'(i), 1'b0);
    pmi_mac_model_i.idle();
    for (k = 0; k < 100 && n_ovr == 0; k++) tick();
    chk("overrun", 16'h1, n_ovr);
    sym_rdy = 1'b1;
    wait_syms(3);
    repeat (10) tick();
    chk("kept count", 16'h3, got.size());
    for (int i = 0; i < 3; i++) chk("kept", {PMI_SYM_DATA, 8'h40 + 8'(i)}, got[i]);
    chk("drained", 16'h0, sym_v);
  endtask : t_buf
  task automatic t_rx();
    int n;
    pmi_speed_e sp[3] = '{PMI_10M, PMI_100M, PMI_1000M};
    int hp[3] = '{`PMI_RX10_HALF, `PMI_RX100_HALF, `PMI_RX1000_HALF};
    for (int i = 0; i < 3; i++)
    begin
      setmode(PMI_GMII, sp[i]);
      period(1'b1, n);
      chk("rx clock", 2 * hp[i], n);
    end
    rx_put(8'h6B, 1'b1);
    rx_edge(1'b0);
    chk("gmii rx", {4'hB, 2'h3}, {rxd, rx_ctl, rx_er});
    rx_edge(1'b0);
    chk("gmii rx idle", 16'h0, rx_ctl);
    setmode(PMI_MII, PMI_100M);
    rx_put(8'h5C, 1'b0);
    rx_edge(1'b0);
    chk("mii rx low", {4'hC, 2'h2}, {rxd, rx_ctl, rx_er});
    rx_edge(1'b0);
    chk("mii rx high", {4'h5, 2'h2}, {rxd, rx_ctl, rx_er});
    setmode(PMI_RGMII, PMI_100M);
    rx_put(8'hD4, 1'b1);
    rx_edge(1'b1);
    chk("rgmii rx rise", {4'h4, 1'b1}, {rxd, rx_ctl});
    rx_edge(1'b0);
    chk("rgmii rx fall", {4'hD, 2'h0}, {rxd, rx_ctl, rx_er});
  endtask : t_rx
  initial
  begin
    repeat (8) tick();
    t_gmii();
    t_rgmii();
    t_mii();
    t_buf();
    t_rx();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
